// file: verilog/mat_thresholds.sv
// Threshold registers and alert comparators for cell, block and current-sense measurements.
// Assumes an APB master on the system clock and a scan engine that delivers one code per valid cycle.
// Alert enables for block and current checks, and alert masking, live outside this block.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns

// How it works
// R1 - 14-bit codes sit in bits 15:2
// R2 - Unipolar cell above set raises overvoltage
// R3 - All-ones overvoltage set never trips
// R4 - Zero undervoltage set never trips
// R5 - Cell at/above polarity clear ends undervoltage
// R6 - Unipolar cell below set raises undervoltage
// R7 - Software keeps undervoltage clear at/above set
// R8 - Max minus min above threshold flags mismatch
// R9 - Select bit picks unipolar-only or all cells
// R10 - Bipolar cell at/below clear ends overvoltage
// R11 - Bipolar cell above set raises overvoltage
// R12 - Bipolar cell below set raises undervoltage
// R13 - Block at/below clear ends overvoltage
// R14 - Block above set raises overvoltage
// R15 - Block below set raises undervoltage
// R16 - Current at/below clear ends overvoltage
// R17 - Current codes bipolar, mid-scale is zero
// R18 - Software keeps overvoltage clear at/below set
// R19 - Current above set raises overvoltage
// R20 - Disabled cell checks are cleared
// R21 - Alerts hold between clear and set
module mat_thresholds #(
  parameter int unsigned NCELL = 14
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  input  wire logic [3:0]             pstrb_i,
  output logic                        pready_o,
  output logic [31:0]                 prdata_o,
  output logic                        pslverr_o,
  input  wire mat_pkg::mat_cell_meas_t cell_meas_i,
  input  wire mat_pkg::mat_meas_t     block_meas_i,
  input  wire mat_pkg::mat_meas_t     current_meas_i,
  output mat_pkg::mat_alerts_t        alerts_o,
  output logic [NCELL-1:0]            cell_ov_flags_o,
  output logic [NCELL-1:0]            cell_uv_flags_o
);
  import mat_pkg::*;

  logic                rst_sync1_ff;
  logic                rst_sync2_ff;
  logic                rst_n;
  logic [13:0]         cell_ov_set_ff;
  logic [13:0]         cell_ov_clr_ff;
  logic [13:0]         cell_uv_clr_ff;
  logic [13:0]         cell_uv_set_ff;
  logic [13:0]         mismatch_ff;
  logic [13:0]         bip_ov_clr_ff;
  logic [13:0]         bip_ov_set_ff;
  logic [13:0]         bip_uv_clr_ff;
  logic [13:0]         bip_uv_set_ff;
  logic [13:0]         blk_ov_clr_ff;
  logic [13:0]         blk_ov_set_ff;
  logic [13:0]         blk_uv_clr_ff;
  logic [13:0]         blk_uv_set_ff;
  logic [13:0]         cur_ov_clr_ff;
  logic [13:0]         cur_ov_set_ff;
  logic [NCELL-1:0]    ov_en_ff;
  logic [NCELL-1:0]    uv_en_ff;
  logic [NCELL-1:0]    polarity_ff;
  logic                minmax_sel_ff;
  logic [NCELL-1:0]    cell_ov_ff;
  logic [NCELL-1:0]    cell_uv_ff;
  logic                mismatch_alert_ff;
  logic                blk_ov_ff;
  logic                blk_uv_ff;
  logic                cur_ov_ff;
  logic [13:0]         max_ff;
  logic [13:0]         min_ff;
  logic                any_ff;
  logic                pready_ff;
  logic [31:0]         prdata_ff;
  logic                pslverr_ff;
  logic [7:0]          idx;
  logic                wr_en;
  logic                access;
  logic                hit;
  logic                bad_addr;
  logic                chan_ok;
  logic [31:0]         nxt_rdata;
  logic [13:0]         wcode;
  logic                cell_bip;
  logic [13:0]         c_code;
  logic                in_minmax;
  logic [13:0]         nxt_max;
  logic [13:0]         nxt_min;
  logic                nxt_any;

  // Reset released through two flops
  // Assertion stays asynchronous; only the release is clocked, so no flop leaves reset mid-edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_n = rst_sync2_ff;

  // Bus decode; pready is registered, so it rises in the second access cycle and the access phase lasts two cycles
  assign idx      = paddr_i[9:2];
  assign access   = psel_i && penable_i && !pready_ff;
  // Upper address bits or an unmapped index answer with an error and change nothing
  assign bad_addr = (paddr_i[11:10] != 2'b00) || !hit;
  // Both low lanes carry the code, so a write missing either low lane is dropped; upper-lane strobes are not checked
  assign wr_en    = access && pwrite_i && pstrb_i[0] && pstrb_i[1] && !bad_addr;
  // R1 code field
  assign wcode    = pwdata_i[CODE_MSB:CODE_LSB];

  always_comb begin
    hit       = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (idx)
      IDX_CELL_OV_CLR:  nxt_rdata[CODE_MSB:CODE_LSB] = cell_ov_clr_ff;
      IDX_CELL_OV_SET:  nxt_rdata[CODE_MSB:CODE_LSB] = cell_ov_set_ff;
      IDX_CELL_UV_CLR:  nxt_rdata[CODE_MSB:CODE_LSB] = cell_uv_clr_ff;
      IDX_CELL_UV_SET:  nxt_rdata[CODE_MSB:CODE_LSB] = cell_uv_set_ff;
      IDX_MISMATCH:     nxt_rdata[CODE_MSB:CODE_LSB] = mismatch_ff;
      IDX_BIP_OV_CLR:   nxt_rdata[CODE_MSB:CODE_LSB] = bip_ov_clr_ff;
      IDX_BIP_OV_SET:   nxt_rdata[CODE_MSB:CODE_LSB] = bip_ov_set_ff;
      IDX_BIP_UV_CLR:   nxt_rdata[CODE_MSB:CODE_LSB] = bip_uv_clr_ff;
      IDX_BIP_UV_SET:   nxt_rdata[CODE_MSB:CODE_LSB] = bip_uv_set_ff;
      IDX_BLK_OV_CLR:   nxt_rdata[CODE_MSB:CODE_LSB] = blk_ov_clr_ff;
      IDX_BLK_OV_SET:   nxt_rdata[CODE_MSB:CODE_LSB] = blk_ov_set_ff;
      IDX_BLK_UV_CLR:   nxt_rdata[CODE_MSB:CODE_LSB] = blk_uv_clr_ff;
      IDX_BLK_UV_SET:   nxt_rdata[CODE_MSB:CODE_LSB] = blk_uv_set_ff;
      IDX_CUR_OV_CLR:   nxt_rdata[CODE_MSB:CODE_LSB] = cur_ov_clr_ff;
      IDX_CUR_OV_SET:   nxt_rdata[CODE_MSB:CODE_LSB] = cur_ov_set_ff;
      IDX_CHECK_EN: begin
        nxt_rdata[NCELL-1:0]     = ov_en_ff;
        nxt_rdata[16+NCELL-1:16] = uv_en_ff;
      end
      IDX_POLARITY: begin
        nxt_rdata[NCELL-1:0]      = polarity_ff;
        nxt_rdata[MINMAX_SEL_BIT] = minmax_sel_ff;
      end
      IDX_ALERT_STAT: begin
        nxt_rdata[ST_OV]  = |cell_ov_ff;
        nxt_rdata[ST_UV]  = |cell_uv_ff;
        nxt_rdata[ST_MM]  = mismatch_alert_ff;
        nxt_rdata[ST_BOV] = blk_ov_ff;
        nxt_rdata[ST_BUV] = blk_uv_ff;
        nxt_rdata[ST_COV] = cur_ov_ff;
      end
      IDX_CELL_OV_STAT: nxt_rdata[NCELL-1:0] = cell_ov_ff;
      IDX_CELL_UV_STAT: nxt_rdata[NCELL-1:0] = cell_uv_ff;
      default:          hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access && bad_addr;
      // Read data stands until the next read, not only while pready is high
      if (access && !pwrite_i) begin
        prdata_ff <= bad_addr ? 32'h0000_0000 : nxt_rdata;
      end
    end
  end

  // Threshold and control registers; writes land at the edge before pready
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cell_ov_set_ff <= RST_ONES;
      cell_ov_clr_ff <= RST_ONES;
      cell_uv_clr_ff <= RST_ZERO;
      cell_uv_set_ff <= RST_ZERO;
      mismatch_ff    <= RST_ONES;
      bip_ov_clr_ff  <= RST_ONES;
      bip_ov_set_ff  <= RST_ONES;
      bip_uv_clr_ff  <= RST_ZERO;
      bip_uv_set_ff  <= RST_ZERO;
      blk_ov_clr_ff  <= RST_ONES;
      blk_ov_set_ff  <= RST_ONES;
      blk_uv_clr_ff  <= RST_ZERO;
      blk_uv_set_ff  <= RST_ZERO;
      cur_ov_clr_ff  <= RST_ONES;
      cur_ov_set_ff  <= RST_ONES;
      ov_en_ff       <= '0;
      uv_en_ff       <= '0;
      polarity_ff    <= '0;
      minmax_sel_ff  <= 1'b0;
    end else if (wr_en) begin
      unique case (idx)
        IDX_CELL_OV_CLR: cell_ov_clr_ff <= wcode;
        IDX_CELL_OV_SET: cell_ov_set_ff <= wcode;
        IDX_CELL_UV_CLR: cell_uv_clr_ff <= wcode;
        IDX_CELL_UV_SET: cell_uv_set_ff <= wcode;
        IDX_MISMATCH:    mismatch_ff    <= wcode;
        IDX_BIP_OV_CLR:  bip_ov_clr_ff  <= wcode;
        IDX_BIP_OV_SET:  bip_ov_set_ff  <= wcode;
        IDX_BIP_UV_CLR:  bip_uv_clr_ff  <= wcode;
        IDX_BIP_UV_SET:  bip_uv_set_ff  <= wcode;
        IDX_BLK_OV_CLR:  blk_ov_clr_ff  <= wcode;
        IDX_BLK_OV_SET:  blk_ov_set_ff  <= wcode;
        IDX_BLK_UV_CLR:  blk_uv_clr_ff  <= wcode;
        IDX_BLK_UV_SET:  blk_uv_set_ff  <= wcode;
        IDX_CUR_OV_CLR:  cur_ov_clr_ff  <= wcode;
        IDX_CUR_OV_SET:  cur_ov_set_ff  <= wcode;
        IDX_CHECK_EN: begin
          ov_en_ff <= pwdata_i[NCELL-1:0];
          uv_en_ff <= pwdata_i[16+NCELL-1:16];
        end
        IDX_POLARITY: begin
          polarity_ff   <= pwdata_i[NCELL-1:0];
          minmax_sel_ff <= pwdata_i[MINMAX_SEL_BIT];
        end
        default: ;
      endcase
    end
  end

  // Channels past the last cell are dropped; their index would read past the polarity bits
  assign chan_ok  = int'(cell_meas_i.chan) < NCELL;
  assign cell_bip = chan_ok ? polarity_ff[cell_meas_i.chan] : 1'b0;
  assign c_code   = cell_meas_i.code;

  // Per-cell hysteresis flags; strict compares make all-ones and zero set values inert
  for (genvar g = 0; g < NCELL; g++) begin : g_cell
    logic hit_ch;
    assign hit_ch = cell_meas_i.valid && (cell_meas_i.chan == 4'(g));
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        cell_ov_ff[g] <= 1'b0;
      // R20 disable clears
      end else if (!ov_en_ff[g]) begin
        cell_ov_ff[g] <= 1'b0;
      end else if (hit_ch) begin
        // Set is tested before clear, so overlapping thresholds leave the alert raised
        // R2 R3 R11 unipolar or bipolar set
        if (c_code > (polarity_ff[g] ? bip_ov_set_ff : cell_ov_set_ff)) begin
          cell_ov_ff[g] <= 1'b1;
        // R10 clear at or below
        end else if (c_code <= (polarity_ff[g] ? bip_ov_clr_ff : cell_ov_clr_ff)) begin
          cell_ov_ff[g] <= 1'b0;
        end
        // R21 otherwise held
      end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        cell_uv_ff[g] <= 1'b0;
      // R20 disable clears
      end else if (!uv_en_ff[g]) begin
        cell_uv_ff[g] <= 1'b0;
      end else if (hit_ch) begin
        // R6 R4 R12 set below
        if (c_code < (polarity_ff[g] ? bip_uv_set_ff : cell_uv_set_ff)) begin
          cell_uv_ff[g] <= 1'b1;
        // R5 clear at or above
        end else if (c_code >= (polarity_ff[g] ? bip_uv_clr_ff : cell_uv_clr_ff)) begin
          cell_uv_ff[g] <= 1'b0;
        end
        // R21 otherwise held
      end
    end
  end

  // R9 channel selection for min and max
  assign in_minmax = chan_ok && (minmax_sel_ff || !cell_bip);

  always_comb begin
    nxt_max = any_ff ? max_ff : RST_ZERO;
    nxt_min = any_ff ? min_ff : RST_ONES;
    nxt_any = any_ff;
    if (cell_meas_i.valid && in_minmax) begin
      nxt_any = 1'b1;
      if (c_code > nxt_max) begin
        nxt_max = c_code;
      end
      if (c_code < nxt_min) begin
        nxt_min = c_code;
      end
    end
  end

  // R8 spread checked when the scan ends
  // A scan with no included channel leaves the alert low rather than comparing stale extremes
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      max_ff            <= RST_ZERO;
      min_ff            <= RST_ONES;
      any_ff            <= 1'b0;
      mismatch_alert_ff <= 1'b0;
    end else if (cell_meas_i.valid && cell_meas_i.last) begin
      max_ff            <= RST_ZERO;
      min_ff            <= RST_ONES;
      any_ff            <= 1'b0;
      mismatch_alert_ff <= nxt_any && ((nxt_max - nxt_min) > mismatch_ff);
    end else begin
      max_ff <= nxt_max;
      min_ff <= nxt_min;
      any_ff <= nxt_any;
    end
  end

  // Block check runs on every block result; its enable sits outside this block
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      blk_ov_ff <= 1'b0;
      blk_uv_ff <= 1'b0;
    end else if (block_meas_i.valid) begin
      // R14 R3 block set above
      if (block_meas_i.code > blk_ov_set_ff) begin
        blk_ov_ff <= 1'b1;
      // R13 block clear at or below
      end else if (block_meas_i.code <= blk_ov_clr_ff) begin
        blk_ov_ff <= 1'b0;
      end
      // R15 R4 block set below
      if (block_meas_i.code < blk_uv_set_ff) begin
        blk_uv_ff <= 1'b1;
      // R21 clear at or above, held between
      end else if (block_meas_i.code >= blk_uv_clr_ff) begin
        blk_uv_ff <= 1'b0;
      end
    end
  end

  // R17 codes compared raw; mid-scale is zero current, so unsigned order is current order
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_ov_ff <= 1'b0;
    end else if (current_meas_i.valid) begin
      // R19 current set above
      if (current_meas_i.code > cur_ov_set_ff) begin
        cur_ov_ff <= 1'b1;
      // R16 current clear at or below
      end else if (current_meas_i.code <= cur_ov_clr_ff) begin
        cur_ov_ff <= 1'b0;
      end
    end
  end

  // Outputs registered so alerts lag their flags by one cycle
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      alerts_o        <= '0;
      cell_ov_flags_o <= '0;
      cell_uv_flags_o <= '0;
    end else begin
      alerts_o.cell_overvoltage_alert    <= |cell_ov_ff;
      alerts_o.cell_undervoltage_alert   <= |cell_uv_ff;
      alerts_o.cell_mismatch_alert       <= mismatch_alert_ff;
      alerts_o.block_overvoltage_alert   <= blk_ov_ff;
      alerts_o.block_undervoltage_alert  <= blk_uv_ff;
      alerts_o.current_overvoltage_alert <= cur_ov_ff;
      cell_ov_flags_o <= cell_ov_ff;
      cell_uv_flags_o <= cell_uv_ff;
    end
  end

  assign pready_o  = pready_ff;
  assign prdata_o  = prdata_ff;
  assign pslverr_o = pslverr_ff;

endmodule : mat_thresholds

// file: shared/mat_pkg.sv
// Package for the measurement alert threshold block: register map, field layout, reset values, carrier types.
// Assumes a 32-bit APB slave; thresholds are 14-bit codes held in bits 15:2.
package mat_pkg;

  localparam int unsigned CODE_W   = 14;
  localparam int unsigned CODE_LSB = 2;
  localparam int unsigned CODE_MSB = 15;

  // Printed offsets are indices; the byte address is four times the index
  localparam logic [7:0] IDX_CELL_UV_CLR  = 8'h21;
  localparam logic [7:0] IDX_CELL_UV_SET  = 8'h22;
  localparam logic [7:0] IDX_MISMATCH     = 8'h23;
  localparam logic [7:0] IDX_BIP_OV_CLR   = 8'h24;
  localparam logic [7:0] IDX_BIP_OV_SET   = 8'h25;
  localparam logic [7:0] IDX_BIP_UV_CLR   = 8'h26;
  localparam logic [7:0] IDX_BIP_UV_SET   = 8'h27;
  localparam logic [7:0] IDX_BLK_OV_CLR   = 8'h28;
  localparam logic [7:0] IDX_BLK_OV_SET   = 8'h29;
  localparam logic [7:0] IDX_BLK_UV_CLR   = 8'h2a;
  localparam logic [7:0] IDX_BLK_UV_SET   = 8'h2b;
  localparam logic [7:0] IDX_CUR_OV_CLR   = 8'h2c;
  localparam logic [7:0] IDX_CUR_OV_SET   = 8'h2d;
  localparam logic [7:0] IDX_CELL_OV_SET  = 8'h20;
  localparam logic [7:0] IDX_CELL_OV_CLR  = 8'h1f;
  localparam logic [7:0] IDX_CHECK_EN     = 8'h40;
  localparam logic [7:0] IDX_POLARITY     = 8'h41;
  localparam logic [7:0] IDX_ALERT_STAT   = 8'h42;
  localparam logic [7:0] IDX_CELL_OV_STAT = 8'h43;
  localparam logic [7:0] IDX_CELL_UV_STAT = 8'h44;

  localparam logic [13:0] RST_ONES  = 14'h3fff;
  localparam logic [13:0] RST_ZERO  = 14'h0000;
  localparam logic [13:0] CODE_ZERO_CURRENT = 14'h2000;

  // Polarity register layout
  localparam int unsigned MINMAX_SEL_BIT = 16;
  // Alert status layout
  localparam int unsigned ST_OV  = 0;
  localparam int unsigned ST_UV  = 1;
  localparam int unsigned ST_MM  = 2;
  localparam int unsigned ST_BOV = 3;
  localparam int unsigned ST_BUV = 4;
  localparam int unsigned ST_COV = 5;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [3:0]  chan;
    logic [13:0] code;
  } mat_cell_meas_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] code;
  } mat_meas_t;

  typedef struct packed {
    logic cell_overvoltage_alert;
    logic cell_undervoltage_alert;
    logic cell_mismatch_alert;
    logic block_overvoltage_alert;
    logic block_undervoltage_alert;
    logic current_overvoltage_alert;
  } mat_alerts_t;

endpackage : mat_pkg

// file: sim/mat_checker.sv
// Checker for mat_thresholds: APB answer timing and block and current alert behaviour.
// Sees only the top ports; mirrors the block and current thresholds, except block undervoltage clear, from APB writes.
`timescale 1ns/1ns
module mat_checker (
  input wire logic                    clk_sys_i,
  input wire logic                    reset_n_i,
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [11:0]             paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic [3:0]              pstrb_i,
  input wire logic                    pready_o,
  input wire logic                    pslverr_o,
  input wire mat_pkg::mat_cell_meas_t cell_meas_i,
  input wire mat_pkg::mat_meas_t      block_meas_i,
  input wire mat_pkg::mat_meas_t      current_meas_i,
  input wire mat_pkg::mat_alerts_t    alerts_o
);
  import mat_pkg::*;
  logic [13:0] bov_set_ff, bov_clr_ff, buv_set_ff, cov_set_ff, cov_clr_ff;
  logic        wr_done;
  logic        scan_end;
  assign wr_done  = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o && pstrb_i[1:0] == 2'b11;
  assign scan_end = cell_meas_i.valid && cell_meas_i.last;
  // Mirror lags the design by one cycle; no measurement may overlap a write
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bov_set_ff <= RST_ONES;
      bov_clr_ff <= RST_ONES;
      buv_set_ff <= RST_ZERO;
      cov_set_ff <= RST_ONES;
      cov_clr_ff <= RST_ONES;
    end else if (wr_done) begin
      case (paddr_i[9:2])
        IDX_BLK_OV_SET: bov_set_ff <= pwdata_i[15:2];
        IDX_BLK_OV_CLR: bov_clr_ff <= pwdata_i[15:2];
        IDX_BLK_UV_SET: buv_set_ff <= pwdata_i[15:2];
        IDX_CUR_OV_SET: cov_set_ff <= pwdata_i[15:2];
        IDX_CUR_OV_CLR: cov_clr_ff <= pwdata_i[15:2];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready one cycle after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_blk_ov_set: assert property (block_meas_i.valid && block_meas_i.code > bov_set_ff |-> ##2 alerts_o.block_overvoltage_alert)
    else $error("block overvoltage not raised");
  a_blk_ov_clear: assert property (block_meas_i.valid && block_meas_i.code <= bov_clr_ff && block_meas_i.code <= bov_set_ff
    |-> ##2 !alerts_o.block_overvoltage_alert)
    else $error("block overvoltage not cleared");
  a_blk_uv_set: assert property (block_meas_i.valid && block_meas_i.code < buv_set_ff |-> ##2 alerts_o.block_undervoltage_alert)
    else $error("block undervoltage not raised");
  a_cur_ov_set: assert property (current_meas_i.valid && current_meas_i.code > cov_set_ff
    |-> ##2 alerts_o.current_overvoltage_alert)
    else $error("current overvoltage not raised");
  a_cur_ov_clear: assert property (current_meas_i.valid && current_meas_i.code <= cov_clr_ff
    && current_meas_i.code <= cov_set_ff |-> ##2 !alerts_o.current_overvoltage_alert)
    else $error("current overvoltage not cleared");
  a_blk_ov_hold: assert property ($changed(alerts_o.block_overvoltage_alert) |-> $past(block_meas_i.valid, 2))
    else $error("block alert moved without a measurement");
  a_mm_scan_end: assert property ($changed(alerts_o.cell_mismatch_alert) |-> $past(scan_end, 2))
    else $error("mismatch moved outside scan end");
endmodule : mat_checker

bind mat_thresholds mat_checker u_chk (.clk_sys_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pstrb_i, .pready_o, .pslverr_o, .cell_meas_i, .block_meas_i, .current_meas_i, .alerts_o);

// file: sim/testbench.sv
// Self-checking bench for mat_thresholds: register map over APB and alert scenarios.
// Drives the design ports itself; the checker is bound in from its own file.
`timescale 1ns/1ns
module testbench;
  import mat_pkg::*;
  logic           clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0]    paddr_i;
  logic [31:0]    pwdata_i, prdata_o, rd;
  logic [3:0]     pstrb_i;
  mat_cell_meas_t cell_meas_i;
  mat_meas_t      block_meas_i, current_meas_i;
  mat_alerts_t    alerts_o;
  logic [13:0]    cell_ov_flags_o, cell_uv_flags_o;
  int             error_cnt = 0;
  int             compares = 0;
  // Indices 0x1f..0x2d; a set bit means the register resets to all ones
  logic [14:0]    rst_ones = 15'h6673;
  logic [13:0]    val_tab [15] = '{14'h0800, 14'h1000, 14'h0600, 14'h0400, 14'h0100, 14'h2800, 14'h3000,
                                   14'h1800, 14'h1000, 14'h1800, 14'h2000, 14'h0a00, 14'h0800, 14'h2100, 14'h2400};

  mat_thresholds dut (.clk_sys_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .pready_o, .prdata_o, .pslverr_o, .cell_meas_i, .block_meas_i, .current_meas_i, .alerts_o,
    .cell_ov_flags_o, .cell_uv_flags_o);

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= {2'b00, idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) cmp(32'h0, 32'hdead);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    cmp(rd, exp);
  endtask : rdchk

  task automatic meas(input int k, input logic [3:0] ch, input logic [13:0] c, input logic lst);
    if (k == 0) cell_meas_i <= '{1'b1, lst, ch, c};
    else if (k == 1) block_meas_i <= '{1'b1, c};
    else current_meas_i <= '{1'b1, c};
    @(posedge clk_sys_i);
  endtask : meas

  // Alerts follow two edges after the measurement is taken
  task automatic expect_al(input logic [5:0] e);
    cell_meas_i.valid    <= 1'b0;
    block_meas_i.valid   <= 1'b0;
    current_meas_i.valid <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    cmp({26'h0, alerts_o}, {26'h0, e});
  endtask : expect_al

  task automatic step(input int k, input logic [3:0] ch, input logic [13:0] c, input logic [5:0] e);
    meas(k, ch, c, 1'b1);
    expect_al(e);
  endtask : step

  task automatic scan(input logic [13:0] c2, input logic [5:0] e);
    meas(0, 4'd0, 14'h2000, 1'b0);
    meas(0, 4'd1, 14'h0700, 1'b0);
    step(0, 4'd2, c2, e);
  endtask : scan

  task automatic end_sim();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pstrb_i = 4'hf;
    {cell_meas_i, block_meas_i, current_meas_i} = '0;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 15; i++) rdchk(8'h1f + 8'(i), {16'h0, {14{rst_ones[i]}}, 2'b00});
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, 8'h1f + 8'(i), 32'hffff_ffff);
      rdchk(8'h1f + 8'(i), 32'h0000_fffc);
      apb(1'b1, 8'h1f + 8'(i), {16'h0, val_tab[i], 2'b00});
    end
    pstrb_i <= 4'hc;
    apb(1'b1, IDX_MISMATCH, 32'h0000_0004);
    pstrb_i <= 4'hf;
    rdchk(IDX_MISMATCH, {16'h0, val_tab[4], 2'b00});
    apb(1'b0, 8'h10, 32'h0);
    cmp({rd[31:1], err}, 32'h1);
    apb(1'b1, IDX_CHECK_EN, 32'h3fff_3fff);
    rdchk(IDX_CHECK_EN, 32'h3fff_3fff);
    step(0, 4'd0, 14'h1000, 6'h00);
    step(0, 4'd0, 14'h1001, 6'h20);
    cmp({18'h0, cell_ov_flags_o}, 32'h1);
    rdchk(IDX_CELL_OV_STAT, 32'h1);
    rdchk(IDX_ALERT_STAT, 32'h1);
    step(0, 4'd0, 14'h0900, 6'h20);
    step(0, 4'd0, 14'h0800, 6'h00);
    step(0, 4'd0, 14'h1001, 6'h20);
    apb(1'b1, IDX_CHECK_EN, 32'h3fff_0000);
    expect_al(6'h00);
    step(0, 4'd0, 14'h1001, 6'h00);
    apb(1'b1, IDX_CHECK_EN, 32'h3fff_3fff);
    step(0, 4'd0, 14'h03ff, 6'h10);
    cmp({18'h0, cell_uv_flags_o}, 32'h1);
    rdchk(IDX_CELL_UV_STAT, 32'h1);
    apb(1'b1, IDX_CHECK_EN, 32'h0000_3fff);
    expect_al(6'h00);
    apb(1'b1, IDX_CHECK_EN, 32'h3fff_3fff);
    step(0, 4'd0, 14'h03ff, 6'h10);
    step(0, 4'd0, 14'h0500, 6'h10);
    step(0, 4'd0, 14'h0600, 6'h00);
    step(0, 4'd0, 14'h0400, 6'h00);
    apb(1'b1, IDX_POLARITY, 32'h1);
    step(0, 4'd0, 14'h3000, 6'h00);
    step(0, 4'd0, 14'h3001, 6'h20);
    step(0, 4'd0, 14'h2900, 6'h20);
    step(0, 4'd0, 14'h2800, 6'h00);
    step(0, 4'd0, 14'h1000, 6'h00);
    step(0, 4'd0, 14'h0fff, 6'h10);
    step(0, 4'd0, 14'h1700, 6'h10);
    step(0, 4'd0, 14'h1800, 6'h00);
    step(1, 4'd0, 14'h2000, 6'h00);
    step(1, 4'd0, 14'h2001, 6'h04);
    step(1, 4'd0, 14'h1900, 6'h04);
    step(1, 4'd0, 14'h1800, 6'h00);
    step(1, 4'd0, 14'h07ff, 6'h02);
    step(1, 4'd0, 14'h0900, 6'h02);
    step(1, 4'd0, 14'h0a00, 6'h00);
    step(2, 4'd0, 14'h2000, 6'h00);
    step(2, 4'd0, 14'h2401, 6'h01);
    step(2, 4'd0, 14'h2200, 6'h01);
    step(2, 4'd0, 14'h2100, 6'h00);
    apb(1'b1, IDX_BLK_OV_SET, 32'h0000_fffc);
    apb(1'b1, IDX_BLK_UV_SET, 32'h0);
    step(1, 4'd0, 14'h3fff, 6'h00);
    step(1, 4'd0, 14'h0000, 6'h00);
    scan(14'h0800, 6'h00);
    apb(1'b1, IDX_POLARITY, 32'h0001_0001);
    rdchk(IDX_POLARITY, 32'h0001_0001);
    scan(14'h0800, 6'h08);
    apb(1'b1, IDX_POLARITY, 32'h1);
    scan(14'h0800, 6'h00);
    scan(14'h0801, 6'h08);
    end_sim();
  end
endmodule : testbench
